// [design/fsu_regs.svh]
// constants for the flexible serial shifter
`ifndef FSU_REGS_SVH
`define FSU_REGS_SVH

// ************************************************************
// widths
// ************************************************************
`define FSU_DATA_W 8
`define FSU_CNT_W 4
`define FSU_DATA_MSB 7
`define FSU_CNT_MSB 3

// ************************************************************
// reset values and counter constants
// ************************************************************
`define FSU_DATA_RST 8'h00
`define FSU_CNT_RST 4'h0
`define FSU_CNT_MAX 4'hF
`define FSU_CNT_ONE 4'h1

// ************************************************************
// wire mode codes
// ************************************************************
`define FSU_WM_OFF 2'h0
`define FSU_WM_THREE 2'h1
`define FSU_WM_TWO 2'h2
`define FSU_WM_TWO_HOLD 2'h3

`endif

// [design/fsu_pkg.sv]
// types for the flexible serial shifter
`default_nettype none

package fsu_pkg;
  // shift clock source, one-hot
  typedef enum logic [3:0] {
    FSU_SRC_SOFT = 4'h1,
    FSU_SRC_TIMER = 4'h2,
    FSU_SRC_EXT_RISE = 4'h4,
    FSU_SRC_EXT_FALL = 4'h8
  } fsu_src_t;
endpackage : fsu_pkg

`default_nettype wire

// [design/fsu_flex_serial_unit.sv]
// flexible serial shifter: shift register, edge counter, clock control
`include "fsu_regs.svh"
`default_nettype none

module fsu_flex_serial_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data_in_pin,
  input wire logic [1:0] wire_mode_select,
  input wire logic clock_source_select,
  input wire logic clock_edge_select,
  input wire logic shift_clock_strobe,
  input wire logic clock_toggle_strobe,
  input wire logic timer_compare_match,
  input wire logic clock_drive_enable,
  input wire logic clock_port_wr_en,
  input wire logic clock_port_value,
  input wire logic data_wr_en,
  input wire logic [7:0] data_wr_value,
  input wire logic counter_wr_en,
  input wire logic [3:0] counter_wr_value,
  input wire logic overflow_flag_clear,
  input wire logic start_flag_clear,
  output logic [7:0] shift_data_register,
  output logic [3:0] counter_value,
  output logic counter_overflow_flag,
  output logic start_condition_flag,
  output logic serial_data_out_pin,
  output logic data_line_out,
  output logic data_line_oe,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic idle_wake,
  output logic power_down_wake
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic fsu_pkg::fsu_src_t src_of(input logic cs1, input logic cs0);
    fsu_pkg::fsu_src_t s;
    s = fsu_pkg::FSU_SRC_SOFT;
    if (cs1 && cs0) begin
      s = fsu_pkg::FSU_SRC_EXT_FALL;
    end else if (cs1) begin
      s = fsu_pkg::FSU_SRC_EXT_RISE;
    end else if (cs0) begin
      s = fsu_pkg::FSU_SRC_TIMER;
    end
    return s;
  endfunction : src_of

  function automatic logic [7:0] shl(input logic [7:0] v, input logic b);
    return {v[`FSU_DATA_MSB-1:0], b};
  endfunction : shl

  function automatic logic is_two(input logic [1:0] wm);
    return (wm == `FSU_WM_TWO) || (wm == `FSU_WM_TWO_HOLD);
  endfunction : is_two

  // ************************************************************
  // link domain: reset, edge capture
  // ************************************************************
  logic lrst_a_q;
  logic lrst_b_q;
  logic pos_bit_q;
  logic pos_tog_q;
  logic neg_bit_q;
  logic neg_tog_q;

  always_ff @(posedge serial_clk) begin
    lrst_a_q <= rst_n;
    lrst_b_q <= lrst_a_q;
  end

  always_ff @(posedge serial_clk) begin
    if (!lrst_b_q) begin
      pos_bit_q <= 1'b0;
      pos_tog_q <= 1'b0;
    end else begin
      pos_bit_q <= serial_data_in_pin;
      pos_tog_q <= ~pos_tog_q;
    end
  end

  always_ff @(negedge serial_clk) begin
    if (!lrst_b_q) begin
      neg_bit_q <= 1'b0;
      neg_tog_q <= 1'b0;
    end else begin
      neg_bit_q <= serial_data_in_pin;
      neg_tog_q <= ~neg_tog_q;
    end
  end

  // ************************************************************
  // crossings into the reference domain
  // ************************************************************
  logic pos_s1_q;
  logic pos_s2_q;
  logic pos_s3_q;
  logic neg_s1_q;
  logic neg_s2_q;
  logic neg_s3_q;
  logic di_s1_q;
  logic di_s2_q;
  logic di_s3_q;
  logic ck_s1_q;
  logic ck_s2_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
      pos_s3_q <= 1'b0;
      neg_s1_q <= 1'b0;
      neg_s2_q <= 1'b0;
      neg_s3_q <= 1'b0;
    end else begin
      pos_s1_q <= pos_tog_q;
      pos_s2_q <= pos_s1_q;
      pos_s3_q <= pos_s2_q;
      neg_s1_q <= neg_tog_q;
      neg_s2_q <= neg_s1_q;
      neg_s3_q <= neg_s2_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      di_s1_q <= 1'b1;
      di_s2_q <= 1'b1;
      di_s3_q <= 1'b1;
      ck_s1_q <= 1'b1;
      ck_s2_q <= 1'b1;
    end else begin
      di_s1_q <= serial_data_in_pin;
      di_s2_q <= di_s1_q;
      di_s3_q <= di_s2_q;
      ck_s1_q <= serial_clk;
      ck_s2_q <= ck_s1_q;
    end
  end

  logic ext_pos_ev;
  logic ext_neg_ev;
  assign ext_pos_ev = pos_s2_q ^ pos_s3_q;
  assign ext_neg_ev = neg_s2_q ^ neg_s3_q;

  // ************************************************************
  // clock source selection
  // ************************************************************
  fsu_pkg::fsu_src_t src;
  logic shift_tick;
  logic latch_tick;
  logic shift_bit;
  logic cnt_tick;

  assign src = src_of(clock_source_select, clock_edge_select);

  always_comb begin
    shift_tick = 1'b0;
    latch_tick = 1'b0;
    shift_bit = di_s2_q;
    cnt_tick = 1'b0;
    unique case (src)
      fsu_pkg::FSU_SRC_SOFT: begin
        shift_tick = shift_clock_strobe;
        cnt_tick = shift_clock_strobe;
      end
      fsu_pkg::FSU_SRC_TIMER: begin
        shift_tick = timer_compare_match;
        cnt_tick = timer_compare_match;
      end
      fsu_pkg::FSU_SRC_EXT_RISE: begin
        shift_tick = ext_pos_ev;
        latch_tick = ext_neg_ev;
        shift_bit = pos_bit_q;
        cnt_tick = shift_clock_strobe ? clock_toggle_strobe : (ext_pos_ev | ext_neg_ev);
      end
      fsu_pkg::FSU_SRC_EXT_FALL: begin
        shift_tick = ext_neg_ev;
        latch_tick = ext_pos_ev;
        shift_bit = neg_bit_q;
        cnt_tick = ext_pos_ev | ext_neg_ev;
      end
    endcase
  end

  // ************************************************************
  // shift register
  // ************************************************************
  logic [7:0] sr_q;
  logic [7:0] sr_d;

  always_comb begin
    sr_d = sr_q;
    if (data_wr_en) begin
      sr_d = data_wr_value;
    end else if (shift_tick) begin
      sr_d = shl(sr_q, shift_bit);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sr_q <= `FSU_DATA_RST;
    end else begin
      sr_q <= sr_d;
    end
  end

  assign shift_data_register = sr_q;

  // ************************************************************
  // output latch
  // ************************************************************
  logic do_q;
  logic do_d;
  logic ext_src;

  assign ext_src = (src == fsu_pkg::FSU_SRC_EXT_RISE) || (src == fsu_pkg::FSU_SRC_EXT_FALL);

  // output follows msb on the opposite edge with an external clock, on the shift tick otherwise
  always_comb begin
    do_d = do_q;
    if (data_wr_en) begin
      do_d = data_wr_value[`FSU_DATA_MSB];
    end else if (ext_src && latch_tick) begin
      do_d = sr_q[`FSU_DATA_MSB];
    end else if (!ext_src && shift_tick) begin
      do_d = sr_d[`FSU_DATA_MSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      do_q <= 1'b0;
    end else begin
      do_q <= do_d;
    end
  end

  assign serial_data_out_pin = do_q;

  // ************************************************************
  // edge counter and overflow flag
  // ************************************************************
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic ovf_ev;
  logic ovf_q;
  logic ovf_d;

  always_comb begin
    cnt_d = cnt_q;
    ovf_ev = 1'b0;
    if (counter_wr_en) begin
      cnt_d = counter_wr_value;
    end else if (cnt_tick) begin
      cnt_d = cnt_q + `FSU_CNT_ONE;
      ovf_ev = (cnt_q == `FSU_CNT_MAX);
    end
  end

  assign ovf_d = ovf_ev | (ovf_q & ~overflow_flag_clear);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= `FSU_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  assign counter_value = cnt_q;
  assign counter_overflow_flag = ovf_q;

  // ************************************************************
  // start condition detector
  // ************************************************************
  logic st_q;
  logic st_d;
  logic st_ev;

  assign st_ev = is_two(wire_mode_select) && ck_s2_q && di_s3_q && !di_s2_q;
  assign st_d = st_ev | (st_q & ~start_flag_clear);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign start_condition_flag = st_q;

  // ************************************************************
  // clock pin control
  // ************************************************************
  logic ck_out_q;
  logic ck_out_d;
  logic hold_d;
  logic sclo_q;
  logic scle_q;
  logic sda_oe_q;

  always_comb begin
    ck_out_d = ck_out_q;
    if (clock_port_wr_en) begin
      ck_out_d = clock_port_value;
    end else if (clock_toggle_strobe) begin
      ck_out_d = ~ck_out_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ck_out_q <= 1'b1;
    end else begin
      ck_out_q <= ck_out_d;
    end
  end

  assign hold_d = (is_two(wire_mode_select) && st_d) ||
                  ((wire_mode_select == `FSU_WM_TWO_HOLD) && ovf_d);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclo_q <= 1'b1;
      scle_q <= 1'b0;
    end else if (is_two(wire_mode_select)) begin
      sclo_q <= 1'b0;
      scle_q <= hold_d | (clock_drive_enable & ~ck_out_d);
    end else begin
      sclo_q <= ck_out_d;
      scle_q <= clock_drive_enable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= is_two(wire_mode_select) & ~do_d;
    end
  end

  assign serial_clock_out = sclo_q;
  assign serial_clock_oe = scle_q;
  assign data_line_out = 1'b0;
  assign data_line_oe = sda_oe_q;

  // ************************************************************
  // wake requests
  // ************************************************************
  logic iw_q;
  logic pw_q;

  // idle wake on overflow, deep wake on start
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      iw_q <= 1'b0;
      pw_q <= 1'b0;
    end else begin
      iw_q <= ovf_d;
      pw_q <= st_d & is_two(wire_mode_select);
    end
  end

  assign idle_wake = iw_q;
  assign power_down_wake = pw_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_wr_wins;
    data_wr_en |=> (shift_data_register == $past(data_wr_value));
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("write lost to shift");

  property p_sw_shift;
    (src == fsu_pkg::FSU_SRC_SOFT) && shift_clock_strobe && !data_wr_en
      |=> (shift_data_register == {$past(sr_q[`FSU_DATA_MSB-1:0]), $past(di_s2_q)});
  endproperty
  a_sw_shift: assert property (p_sw_shift) else $error("software shift wrong");

  property p_wrap;
    cnt_tick && !counter_wr_en && (cnt_q == `FSU_CNT_MAX)
      |=> (counter_value == `FSU_CNT_RST) && counter_overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap missing");

  property p_both_edges;
    ext_src && !shift_clock_strobe && (ext_pos_ev || ext_neg_ev) && !counter_wr_en
      |=> (counter_value == $past(cnt_q) + `FSU_CNT_ONE);
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("edge not counted");

  property p_sticky;
    counter_overflow_flag && !overflow_flag_clear |=> counter_overflow_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");

  property p_toggle;
    clock_toggle_strobe && !clock_port_wr_en |=> (ck_out_q != $past(ck_out_q));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle strobe ignored");

  property p_hold;
    is_two(wire_mode_select) && start_condition_flag && !start_flag_clear
      ##1 is_two(wire_mode_select) |-> serial_clock_oe && !serial_clock_out;
  endproperty
  a_hold: assert property (p_hold) else $error("clock not held low");

  property p_idle_wake;
    counter_overflow_flag |-> ##[0:1] idle_wake;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("no idle wake");

  property p_line;
    is_two(wire_mode_select) && $past(is_two(wire_mode_select))
      |-> (data_line_oe == !serial_data_out_pin);
  endproperty
  a_line: assert property (p_line) else $error("data line not msb");

endmodule : fsu_flex_serial_unit

`default_nettype wire

// [test/fsu_peer_model.sv]
// far-side spi master model: link clock and data-in
`default_nettype none
module fsu_peer_model (
  output logic serial_clk,
  output logic serial_data_in_pin,
  input wire logic serial_data_out_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk = 1'b0;
    serial_data_in_pin = 1'b0;
  end
  // ************************************************************
  // link tasks
  // ************************************************************
  task spin(input int n);
    repeat (n) begin
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
  endtask : spin
  task set_din(input logic v);
    serial_data_in_pin = v;
  endtask : set_din
  task start_cond();
    serial_data_in_pin = 1'b1;
    #40 serial_clk = 1'b1;
    #40 serial_data_in_pin = 1'b0;
    #40 serial_clk = 1'b0;
  endtask : start_cond
  task xfer(input logic [7:0] tx, input logic late, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      // bit set up half period early
      if (!late) serial_data_in_pin = tx[i];
      #40 serial_clk = 1'b1;
      if (late) serial_data_in_pin = tx[i];
      else rx = {rx[6:0], serial_data_out_pin};
      #40 serial_clk = 1'b0;
      if (late) rx = {rx[6:0], serial_data_out_pin};
    end
    // released line shows inverse
    #40 serial_data_in_pin = ~serial_data_in_pin;
  endtask : xfer
endmodule : fsu_peer_model
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the flexible serial shifter
`include "fsu_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_n, clock_source_select, clock_edge_select, shift_clock_strobe, clock_toggle_strobe;
  logic timer_compare_match, clock_drive_enable, clock_port_wr_en, clock_port_value, data_wr_en;
  logic counter_wr_en, overflow_flag_clear, start_flag_clear, b;
  logic counter_overflow_flag, start_condition_flag, serial_data_out_pin, data_line_out, data_line_oe;
  logic serial_clock_out, serial_clock_oe, idle_wake, power_down_wake;
  logic [1:0] wire_mode_select;
  logic [7:0] data_wr_value, shift_data_register, rx, tx, e;
  logic [3:0] counter_wr_value, counter_value;
  wire serial_clk;
  wire serial_data_in_pin;
  int fail_count, n_checks;
  fsu_flex_serial_unit fsu_flex_serial_unit_i (.ref_clk, .rst_n, .serial_clk, .serial_data_in_pin,
    .wire_mode_select, .clock_source_select, .clock_edge_select, .shift_clock_strobe, .clock_toggle_strobe,
    .timer_compare_match, .clock_drive_enable, .clock_port_wr_en, .clock_port_value, .data_wr_en,
    .data_wr_value, .counter_wr_en, .counter_wr_value, .overflow_flag_clear, .start_flag_clear,
    .shift_data_register, .counter_value, .counter_overflow_flag, .start_condition_flag,
    .serial_data_out_pin, .data_line_out, .data_line_oe, .serial_clock_out, .serial_clock_oe,
    .idle_wake, .power_down_wake);
  fsu_peer_model fsu_peer_model_i (.serial_clk, .serial_data_in_pin, .serial_data_out_pin);
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;
  // ************************************************************
  // helpers
  // ************************************************************
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1
  function logic [7:0] shl(input logic [7:0] v, input logic d);
    return {v[6:0], d};
  endfunction : shl
  task wr_data(input logic [7:0] v);
    data_wr_en = 1'b1;
    data_wr_value = v;
    cyc(1);
    data_wr_en = 1'b0;
  endtask : wr_data
  task new_byte(input logic [3:0] v);
    counter_wr_en = 1'b1;
    counter_wr_value = v;
    overflow_flag_clear = 1'b1;
    cyc(1);
    counter_wr_en = 1'b0;
    overflow_flag_clear = 1'b0;
  endtask : new_byte
  task toggle();
    clock_toggle_strobe = 1'b1;
    cyc(1);
    clock_toggle_strobe = 1'b0;
  endtask : toggle
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // ************************************************************
  // tests
  // ************************************************************
  task t_soft();
    clock_source_select = 1'b0;
    clock_edge_select = 1'b0;
    clock_drive_enable = 1'b1;
    e = 8'($urandom);
    wr_data(e);
    new_byte(4'h0);
    for (int i = 0; i < 8; i++) begin
      b = 1'($urandom);
      fsu_peer_model_i.set_din(b);
      cyc(4);
      clock_toggle_strobe = 1'b1;
      cyc(1);
      chk1(serial_clock_out, 1'b0);
      shift_clock_strobe = 1'b1;
      cyc(1);
      clock_toggle_strobe = 1'b0;
      shift_clock_strobe = 1'b0;
      e = shl(e, b);
    end
    cyc(2);
    chk(shift_data_register, e);
    chk({4'h0, counter_value}, 8'h08);
    chk1(serial_clock_oe, 1'b1);
    clock_port_wr_en = 1'b1;
    clock_port_value = 1'b0;
    cyc(1);
    clock_port_wr_en = 1'b0;
    chk1(serial_clock_out, 1'b0);
    toggle();
    chk1(serial_clock_out, 1'b1);
    clock_edge_select = 1'b1;
    timer_compare_match = 1'b1;
    cyc(1);
    timer_compare_match = 1'b0;
    cyc(2);
    chk({4'h0, counter_value}, 8'h09);
    clock_edge_select = 1'b0;
    e = 8'($urandom);
    shift_clock_strobe = 1'b1;
    wr_data(e);
    shift_clock_strobe = 1'b0;
    cyc(1);
    chk(shift_data_register, e);
    $display("test soft done");
  endtask : t_soft
  task t_strobe();
    clock_source_select = 1'b1;
    shift_clock_strobe = 1'b1;
    new_byte(4'hE);
    repeat (2) begin
      toggle();
      cyc(1);
    end
    shift_clock_strobe = 1'b0;
    cyc(1);
    chk({4'h0, counter_value}, 8'h00);
    chk1(counter_overflow_flag, 1'b1);
    cyc(6);
    chk1(counter_overflow_flag, 1'b1);
    overflow_flag_clear = 1'b1;
    cyc(1);
    overflow_flag_clear = 1'b0;
    cyc(1);
    chk1(counter_overflow_flag, 1'b0);
    $display("test strobe done");
  endtask : t_strobe
  task t_link(input logic m);
    clock_source_select = 1'b1;
    clock_edge_select = m;
    tx = 8'($urandom);
    e = 8'($urandom);
    wr_data(e);
    new_byte(4'h0);
    cyc(2);
    chk1(serial_data_out_pin, e[7]);
    fsu_peer_model_i.xfer(tx, m, rx);
    cyc(12);
    chk(shift_data_register, tx);
    chk(rx, e);
    chk({4'h0, counter_value}, 8'h00);
    chk1(counter_overflow_flag, 1'b1);
    chk1(idle_wake, 1'b1);
    $display("test link done");
  endtask : t_link
  task t_start();
    wire_mode_select = `FSU_WM_TWO;
    clock_drive_enable = 1'b0;
    wr_data(8'h00);
    cyc(2);
    chk1(data_line_oe, 1'b1);
    chk1(data_line_out, 1'b0);
    wr_data(8'h80);
    cyc(2);
    chk1(data_line_oe, 1'b0);
    fsu_peer_model_i.start_cond();
    cyc(8);
    chk1(start_condition_flag, 1'b1);
    chk1(serial_clock_oe, 1'b1);
    chk1(power_down_wake, 1'b1);
    start_flag_clear = 1'b1;
    cyc(1);
    start_flag_clear = 1'b0;
    cyc(3);
    chk1(start_condition_flag, 1'b0);
    chk1(serial_clock_oe, 1'b0);
    wire_mode_select = `FSU_WM_TWO_HOLD;
    cyc(2);
    chk1(serial_clock_oe, 1'b1);
    overflow_flag_clear = 1'b1;
    cyc(1);
    overflow_flag_clear = 1'b0;
    cyc(2);
    chk1(serial_clock_oe, 1'b0);
    $display("test start done");
  endtask : t_start
  initial begin
    {rst_n, clock_source_select, clock_edge_select, shift_clock_strobe, clock_toggle_strobe} = '0;
    {timer_compare_match, clock_drive_enable, clock_port_wr_en, clock_port_value, data_wr_en} = '0;
    {counter_wr_en, overflow_flag_clear, start_flag_clear, b} = '0;
    wire_mode_select = `FSU_WM_THREE;
    data_wr_value = 8'h00;
    counter_wr_value = 4'h0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'hA7133006));
    fork
      fsu_peer_model_i.spin(6);
    join_none
    cyc(20);
    rst_n = 1'b1;
    cyc(100);
    t_soft();
    t_strobe();
    repeat (3) t_link(1'b0);
    repeat (3) t_link(1'b1);
    t_start();
    final_report();
  end
  initial begin
    cyc(20000);
    fail_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
